// [tmrirq_regs.svh]
// register offsets, field positions, reset values and widths of the timer flag block
`ifndef TMRIRQ_REGS_SVH
`define TMRIRQ_REGS_SVH

`define TMRIRQ_NUM_TIMERS      2
`define TMRIRQ_NUM_CHANNELS    4
`define TMRIRQ_COUNT_WIDTH     16

`define TMRIRQ_T1_BASE         32'h4000E000
`define TMRIRQ_T2_BASE         32'h4000F000
`define TMRIRQ_BASE_STEP       32'h00001000
`define TMRIRQ_OFS_CONTROL     32'h00000000
`define TMRIRQ_OFS_SW_UPDATE   32'h00000014
`define TMRIRQ_OFS_RELOAD      32'h0000002C
`define TMRIRQ_OFS_CAPTURE     32'h00000034
`define TMRIRQ_OFS_FLAG        32'h00000050
`define TMRIRQ_OFS_MASK        32'h00000054
`define TMRIRQ_OFS_MISSED      32'h00000058
`define TMRIRQ_IRQ_SET_ADDR    32'h4000A000
`define TMRIRQ_IRQ_CLR_ADDR    32'h4000A004

`define TMRIRQ_CTRL_BUF_BIT    7
`define TMRIRQ_CTRL_ALIGN_HI   6
`define TMRIRQ_CTRL_ALIGN_LO   5
`define TMRIRQ_CTRL_DIR_BIT    4
`define TMRIRQ_CTRL_PULSE_BIT  3
`define TMRIRQ_CTRL_SRC_BIT    2
`define TMRIRQ_CTRL_UDIS_BIT   1
`define TMRIRQ_CTRL_EN_BIT     0
`define TMRIRQ_CTRL_RESET      8'h00

`define TMRIRQ_FLAG_TRIG_BIT   0
`define TMRIRQ_FLAG_CH_LO      1
`define TMRIRQ_FLAG_UPD_BIT    5
`define TMRIRQ_FLAG_WIDTH      6
`define TMRIRQ_FLAG_RESET      6'h00
`define TMRIRQ_MISS_RESET      4'h0
`define TMRIRQ_RELOAD_RESET    16'hFFFF

`endif

// [tmrirq_pkg.sv]
// types shared by the timer flag and count control block
package tmrirq_pkg;

   typedef enum logic [1:0]
   {
      TMRIRQ_ALIGN_EDGE = 2'b00,
      TMRIRQ_ALIGN_DOWN = 2'b01,
      TMRIRQ_ALIGN_UP   = 2'b10,
      TMRIRQ_ALIGN_BOTH = 2'b11
   } tmrirq_align_t;

   typedef struct packed
   {
      logic          reload_buffer_enable;
      tmrirq_align_t alignment_select;
      logic          count_direction;
      logic          single_pulse_select;
      logic          update_source_select;
      logic          update_disable;
      logic          counter_enable;
   } tmrirq_ctrl_t;

   typedef struct packed
   {
      logic [3:0] channel_event;
      logic [3:0] channel_is_input;
      logic       trigger;
      logic       gated_mode;
      logic       trigger_mode;
      logic       slave_reset;
      logic       count_tick;
   } tmrirq_evt_t;

endpackage

// [tmrirq_counter.sv]
// counter core: direction, alignment, reload buffering and update event generation
`timescale 1ns/100ps
`include "tmrirq_regs.svh"
module tmrirq_counter #(
   parameter int WIDTH = `TMRIRQ_COUNT_WIDTH
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // control
   input  wire tmrirq_pkg::tmrirq_ctrl_t ctrl_i,
   input  wire logic                 tick_i,
   input  wire logic                 sw_update_i,
   input  wire logic                 slave_reset_i,
   input  wire logic                 reload_wr_i,
   input  wire logic [WIDTH-1:0]     reload_data_i,
   // status
   output logic [WIDTH-1:0]          count_o,
   output logic [WIDTH-1:0]          reload_o,
   output logic                      down_o,
   output logic                      update_event_o,
   output logic                      update_flag_set_o
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] reload_active;
   logic [WIDTH-1:0] reload_buffer;
   logic             down;
   logic             edge_mode;
   logic             running;
   logic             overflow;
   logic             underflow;
   logic             reinit;
   logic [WIDTH-1:0] next_count;
   logic             next_down;

   assign edge_mode = (ctrl_i.alignment_select == tmrirq_pkg::TMRIRQ_ALIGN_EDGE);
   assign running   = ctrl_i.counter_enable & tick_i;
   assign overflow  = running & ~down & (count >= reload_active);
   assign underflow = running & down & (count == '0);
   assign reinit    = sw_update_i | slave_reset_i;
   // update event suppressed by the disable bit
   assign update_event_o = ~ctrl_i.update_disable & (overflow | underflow | reinit);
   // update flag source select
   assign update_flag_set_o = update_event_o &
                              (~ctrl_i.update_source_select | overflow | underflow);

   // edge mode follows the direction bit, centre modes turn round at the ends
   always_comb
   begin
      next_count = count;
      next_down  = edge_mode ? ctrl_i.count_direction : down;
      if (reinit)
      begin
         next_count = (edge_mode & ctrl_i.count_direction) ? reload_active : '0;
      end
      else if (running)
      begin
         if (edge_mode)
         begin
            if (ctrl_i.count_direction)
               next_count = (count == '0) ? reload_active : count - 1'b1;
            else
               next_count = overflow ? '0 : count + 1'b1;
         end
         else if (overflow)
         begin
            next_down  = 1'b1;
            next_count = count - 1'b1;
         end
         else if (underflow)
         begin
            next_down  = 1'b0;
            next_count = count + 1'b1;
         end
         else
         begin
            next_count = down ? count - 1'b1 : count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         count         <= '0;
         down          <= 1'b0;
         reload_active <= `TMRIRQ_RELOAD_RESET;
         reload_buffer <= `TMRIRQ_RELOAD_RESET;
      end
      else
      begin
         count <= next_count;
         down  <= next_down;
         if (reload_wr_i)
            reload_buffer <= reload_data_i;
         // unbuffered reload acts at once, buffered waits for the update event
         if (reload_wr_i & ~ctrl_i.reload_buffer_enable)
            reload_active <= reload_data_i;
         else if (update_event_o)
            reload_active <= reload_buffer;
      end
   end

   assign count_o  = count;
   assign reload_o = reload_buffer;
   assign down_o   = down;
endmodule

// [tmrirq_flags.sv]
// per-timer interrupt flags, missed-event flags and request mask
`timescale 1ns/100ps
`include "tmrirq_regs.svh"
module tmrirq_flags (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   // events
   input  wire logic                          trigger_set_i,
   input  wire logic [3:0]                    channel_event_i,
   input  wire logic [3:0]                    channel_is_input_i,
   input  wire tmrirq_pkg::tmrirq_align_t     align_i,
   input  wire logic                          down_i,
   input  wire logic                          update_set_i,
   input  wire logic [3:0]                    capture_read_i,
   // software access
   input  wire logic                          flag_wr_i,
   input  wire logic                          miss_wr_i,
   input  wire logic                          mask_wr_i,
   input  wire logic [`TMRIRQ_FLAG_WIDTH-1:0] wdata_i,
   // state
   output logic [`TMRIRQ_FLAG_WIDTH-1:0]      flag_o,
   output logic [3:0]                         missed_o,
   output logic [`TMRIRQ_FLAG_WIDTH-1:0]      mask_o,
   output logic                               request_o
);
   logic [`TMRIRQ_FLAG_WIDTH-1:0] flag;
   logic [`TMRIRQ_FLAG_WIDTH-1:0] mask;
   logic [3:0]                    missed;
   logic [3:0]                    dir_ok;
   logic [3:0]                    ch_set;
   logic [3:0]                    ch_clear;
   logic [`TMRIRQ_FLAG_WIDTH-1:0] set_vec;
   logic [`TMRIRQ_FLAG_WIDTH-1:0] clr_vec;

   // compare flags of output channels follow the counting direction in alignments 01 and 10
   assign dir_ok = {4{(align_i == tmrirq_pkg::TMRIRQ_ALIGN_EDGE) |
                      (align_i == tmrirq_pkg::TMRIRQ_ALIGN_BOTH) |
                      ((align_i == tmrirq_pkg::TMRIRQ_ALIGN_DOWN) & down_i) |
                      ((align_i == tmrirq_pkg::TMRIRQ_ALIGN_UP) & ~down_i)}};
   assign ch_set   = channel_event_i & (channel_is_input_i | dir_ok);
   // capture read clears the channel flag
   assign ch_clear = capture_read_i & channel_is_input_i;
   assign set_vec  = {update_set_i, ch_set, trigger_set_i};
   // write one to clear
   assign clr_vec  = ({`TMRIRQ_FLAG_WIDTH{flag_wr_i}} & wdata_i) |
                     {1'b0, ch_clear, 1'b0};

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         flag   <= `TMRIRQ_FLAG_RESET;
         missed <= `TMRIRQ_MISS_RESET;
         mask   <= `TMRIRQ_FLAG_RESET;
      end
      else
      begin
         // a new event beats a clear in the same cycle
         flag <= (flag & ~clr_vec) | set_vec;
         // event on a still-set flag is recorded, set beats clear
         missed <= (missed & ~({4{miss_wr_i}} & wdata_i[3:0])) |
                   (ch_set & flag[`TMRIRQ_FLAG_CH_LO +: 4]);
         if (mask_wr_i)
            mask <= wdata_i;
      end
   end

   // only masked-in flags request
   assign request_o = |(flag & mask);
   assign flag_o    = flag;
   assign missed_o  = missed;
   assign mask_o    = mask;
endmodule

// [tmrirq_top.sv]
// two general-purpose timers: interrupt flags, masks, enables and count control
// Function
// - set/clear registers enable each timer's interrupt
// - trigger, channel, update events set flags
// - writing one clears a flag bit
// - capture register read clears channel flag
// - only masked-in flags raise the interrupt
// - channel event on set channel flag marks missed bit
// - writing one clears a missed bit
// - bit 7 buffers the auto-reload value
// - alignment 00 counts one way by direction
// - alignment 01 sets compare flags counting down
// - alignment 10 sets compare flags counting up
// - alignment 11 sets compare flags both ways
// - bit 4 selects up or down count in alignment 00
// - bit 3 stops counter at update event
// - bit 2 narrows update flag sources
// - bit 1 blocks update events, reinit remains
// - bit 0 enables counting, trigger sets it
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "tmrirq_regs.svh"
module tmrirq_top #(
   parameter int NT    = `TMRIRQ_NUM_TIMERS,
   parameter int WIDTH = `TMRIRQ_COUNT_WIDTH
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   // register port
   input  wire logic [31:0]                   addr_i,
   input  wire logic [31:0]                   wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output logic [31:0]                        rdata_o,
   // timer events, one struct per timer
   input  wire tmrirq_pkg::tmrirq_evt_t [NT-1:0] evt_i,
   // interrupt lines and counts
   output logic [NT-1:0]                      irq_o,
   output logic [NT-1:0][WIDTH-1:0]           count_o
);
   logic [NT-1:0]                    irq_enable;
   logic [NT-1:0]                    trig_prev;
   logic [NT-1:0]                    irq_line;
   logic [NT-1:0][WIDTH-1:0]         count;
   logic [NT-1:0][31:0]              rd_word;
   logic                             sel_set;
   logic                             sel_clr;
   logic [31:0]                      next_rdata;

   // decodes a word offset within one timer's window
   function automatic logic hit(input logic [31:0] a, input logic [31:0] base,
                                input logic [31:0] ofs);
      hit = (a == base + ofs);
   endfunction

   assign sel_set = (addr_i == `TMRIRQ_IRQ_SET_ADDR);
   assign sel_clr = (addr_i == `TMRIRQ_IRQ_CLR_ADDR);

   genvar t;
   generate
      for (t = 0; t < NT; t = t + 1)
      begin : g_timer
         localparam logic [31:0] BASE = `TMRIRQ_T1_BASE + 32'(t) * `TMRIRQ_BASE_STEP;
         tmrirq_pkg::tmrirq_ctrl_t           ctrl;
         tmrirq_pkg::tmrirq_ctrl_t           next_ctrl;
         logic                               sel_ctrl;
         logic                               sel_ug;
         logic                               sel_reload;
         logic                               sel_flag;
         logic                               sel_mask;
         logic                               sel_miss;
         logic [3:0]                         sel_cap;
         logic                               trig_edge;
         logic                               trig_set;
         logic                               update_event;
         logic                               upd_set;
         logic                               down;
         logic                               sw_update;
         logic [WIDTH-1:0]                   reload;
         logic [`TMRIRQ_FLAG_WIDTH-1:0]      flag;
         logic [`TMRIRQ_FLAG_WIDTH-1:0]      mask;
         logic [3:0]                         missed;
         logic                               request;
         logic [3:0][WIDTH-1:0]              capture;
         logic [31:0]                        cap_word;

         assign sel_ctrl   = hit(addr_i, BASE, `TMRIRQ_OFS_CONTROL);
         assign sel_ug     = hit(addr_i, BASE, `TMRIRQ_OFS_SW_UPDATE);
         assign sel_reload = hit(addr_i, BASE, `TMRIRQ_OFS_RELOAD);
         assign sel_flag   = hit(addr_i, BASE, `TMRIRQ_OFS_FLAG);
         assign sel_mask   = hit(addr_i, BASE, `TMRIRQ_OFS_MASK);
         assign sel_miss   = hit(addr_i, BASE, `TMRIRQ_OFS_MISSED);
         assign sw_update  = wr_i & sel_ug & wdata_i[0];

         genvar c;
         for (c = 0; c < 4; c = c + 1)
         begin : g_cap
            assign sel_cap[c] = hit(addr_i, BASE, `TMRIRQ_OFS_CAPTURE + 32'(4 * c));
         end

         // rising edge, or either edge in gated mode
         assign trig_edge = evt_i[t].trigger & ~trig_prev[t];
         assign trig_set  = evt_i[t].gated_mode ? (evt_i[t].trigger ^ trig_prev[t])
                                                : trig_edge;

         // software write first, then hardware set and clear of the enable
         always_comb
         begin
            next_ctrl = ctrl;
            if (wr_i & sel_ctrl)
               next_ctrl = tmrirq_pkg::tmrirq_ctrl_t'(wdata_i[7:0]);
            if (evt_i[t].trigger_mode & trig_edge)
               next_ctrl.counter_enable = 1'b1;
            if (update_event & ctrl.single_pulse_select)
               next_ctrl.counter_enable = 1'b0;
         end

         always_ff @(posedge clk_i or posedge reset_i)
         begin
            if (reset_i)
            begin
               ctrl         <= tmrirq_pkg::tmrirq_ctrl_t'(`TMRIRQ_CTRL_RESET);
               trig_prev[t] <= 1'b0;
               capture      <= '0;
            end
            else
            begin
               ctrl         <= next_ctrl;
               trig_prev[t] <= evt_i[t].trigger;
               for (int k = 0; k < 4; k++)
                  if (evt_i[t].channel_event[k] & evt_i[t].channel_is_input[k])
                     capture[k] <= count[t];
            end
         end

         tmrirq_counter #(
            .WIDTH (WIDTH)
         ) u_counter (
            .clk_i             (clk_i),
            .reset_i           (reset_i),
            .ctrl_i            (ctrl),
            .tick_i            (evt_i[t].count_tick),
            .sw_update_i       (sw_update),
            .slave_reset_i     (evt_i[t].slave_reset),
            .reload_wr_i       (wr_i & sel_reload),
            .reload_data_i     (wdata_i[WIDTH-1:0]),
            .count_o           (count[t]),
            .reload_o          (reload),
            .down_o            (down),
            .update_event_o    (update_event),
            .update_flag_set_o (upd_set)
         );

         tmrirq_flags u_flags (
            .clk_i              (clk_i),
            .reset_i            (reset_i),
            .trigger_set_i      (trig_set),
            .channel_event_i    (evt_i[t].channel_event),
            .channel_is_input_i (evt_i[t].channel_is_input),
            .align_i            (ctrl.alignment_select),
            .down_i             (down),
            .update_set_i       (upd_set),
            .capture_read_i     ({4{rd_i}} & sel_cap),
            .flag_wr_i          (wr_i & sel_flag),
            .miss_wr_i          (wr_i & sel_miss),
            .mask_wr_i          (wr_i & sel_mask),
            .wdata_i            (wdata_i[`TMRIRQ_FLAG_WIDTH-1:0]),
            .flag_o             (flag),
            .missed_o           (missed),
            .mask_o             (mask),
            .request_o          (request)
         );

         // masked request gated by the per-timer enable
         assign irq_line[t] = request & irq_enable[t];

         assign cap_word = sel_cap[0] ? 32'(capture[0]) :
                           sel_cap[1] ? 32'(capture[1]) :
                           sel_cap[2] ? 32'(capture[2]) :
                           sel_cap[3] ? 32'(capture[3]) : 32'h00000000;

         // reserved control bits read as zero
         assign rd_word[t] = sel_ctrl   ? {24'h000000, ctrl} :
                             sel_reload ? 32'(reload) :
                             sel_flag   ? 32'(flag) :
                             sel_mask   ? 32'(mask) :
                             sel_miss   ? {28'h0000000, missed} :
                             cap_word;
      end
   endgenerate

   // read mux: unmapped addresses return zero
   always_comb
   begin
      next_rdata = 32'h00000000;
      if (sel_set | sel_clr)
         next_rdata = 32'(irq_enable);
      for (int i = 0; i < NT; i++)
         next_rdata = next_rdata | rd_word[i];
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         irq_enable <= '0;
         rdata_o    <= 32'h00000000;
         irq_o      <= '0;
         count_o    <= '0;
      end
      else
      begin
         // write one to set, write one to clear
         if (wr_i & sel_set)
            irq_enable <= irq_enable | wdata_i[NT-1:0];
         else if (wr_i & sel_clr)
            irq_enable <= irq_enable & ~wdata_i[NT-1:0];
         rdata_o <= rd_i ? next_rdata : 32'h00000000;
         irq_o   <= irq_line;
         count_o <= count;
      end
   end
endmodule

// [tmrirq_chk.sv]
// port checker of the timer flag and count control block
`timescale 1ns/100ps
`include "tmrirq_regs.svh"
module tmrirq_chk #(
   parameter int NT    = 2,
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic                             clk_i,
   input wire logic                             reset_i,
   // register port
   input wire logic [31:0]                      addr_i,
   input wire logic [31:0]                      wdata_i,
   input wire logic                             wr_i,
   input wire logic                             rd_i,
   input wire logic [31:0]                      rdata_o,
   // events and outputs
   input wire tmrirq_pkg::tmrirq_evt_t [NT-1:0] evt_i,
   input wire logic [NT-1:0]                    irq_o,
   input wire logic [NT-1:0][WIDTH-1:0]         count_o
);
   localparam logic [31:0] SET = 32'h4000A000;
   localparam logic [31:0] CLR = 32'h4000A004;
   localparam logic [31:0] M1  = 32'h4000E054;
   logic [NT-1:0] en;
   logic [5:0]    msk;
   // shadow of the enable and timer 1 mask registers
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         en  <= '0;
         msk <= 6'h00;
      end
      else if (wr_i)
      begin
         if (addr_i == SET) en <= en | wdata_i[NT-1:0];
         if (addr_i == CLR) en <= en & ~wdata_i[NT-1:0];
         if (addr_i == M1) msk <= wdata_i[5:0];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_mask_wr;
      wr_i && addr_i == M1;
   endsequence
   sequence s_mask_rd;
      rd_i && addr_i == M1;
   endsequence
   property p_rd_idle;
      !rd_i |=> rdata_o == 32'h0;
   endproperty
   property p_reset_quiet;
      disable iff (1'b0) reset_i |=> rdata_o == 32'h0 && irq_o == '0 && count_o == '0;
   endproperty
   property p_irq_en;
      (irq_o & ~$past(en)) == '0;
   endproperty
   property p_irq_mask;
      irq_o[0] |-> $past(msk) != 6'h00;
   endproperty
   property p_irq_off;
      wr_i && addr_i == CLR && wdata_i[0] |-> ##2 !irq_o[0];
   endproperty
   property p_en_back;
      rd_i && (addr_i == SET || addr_i == CLR) |=> rdata_o == 32'(en);
   endproperty
   property p_ctrl_res;
      rd_i && (addr_i == 32'h4000E000 || addr_i == 32'h4000F000) |=> rdata_o[31:8] == 24'h0;
   endproperty
   property p_mask_back;
      s_mask_wr ##2 s_mask_rd |=> rdata_o[5:0] == $past(wdata_i[5:0], 3);
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read cycle");
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet in reset");
   a_irq_en: assert property (p_irq_en)
      else $error("interrupt while disabled");
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt with empty mask");
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt stays after disable");
   a_en_back: assert property (p_en_back)
      else $error("enable readback wrong");
   a_ctrl_res: assert property (p_ctrl_res)
      else $error("control upper bits not zero");
   a_mask_back: assert property (p_mask_back)
      else $error("mask readback wrong");
endmodule
bind tmrirq_top tmrirq_chk #(.NT(NT), .WIDTH(WIDTH)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .evt_i(evt_i), .irq_o(irq_o), .count_o(count_o));

// [timer_irq_flags_and_count_control_bench.sv]
// self-checking bench of the timer flag and count control block
`timescale 1ns/100ps
module timer_irq_flags_and_count_control_bench;
   localparam logic [31:0] C1 = 32'h4000E000, F1 = 32'h4000E050, K1 = 32'h4000E054;
   localparam logic [31:0] X1 = 32'h4000E058, U1 = 32'h4000E014, A1 = 32'h4000E02C;
   localparam logic [31:0] SET = 32'h4000A000, CLR = 32'h4000A004;
   logic                         clk_i   = 1'b0;
   logic                         reset_i = 1'b1;
   logic                         wr_i    = 1'b0;
   logic                         rd_i    = 1'b0;
   logic [31:0]                  addr_i  = 32'h0;
   logic [31:0]                  wdata_i = 32'h0;
   logic [31:0]                  rdata_o;
   tmrirq_pkg::tmrirq_evt_t [1:0] evt_i = '0;
   logic [1:0]                   irq_o;
   logic [1:0][15:0]             count_o;
   logic [15:0]                  c;
   int                           n_fail = 0;
   int                           check_count = 0;
   tmrirq_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i), .irq_o(irq_o),
      .count_o(count_o));
   initial forever #2.5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   task automatic ev(input logic [3:0] ch);
      @(posedge clk_i);
      evt_i[0].channel_event <= ch;
      @(posedge clk_i);
      evt_i[0].channel_event <= 4'h0;
   endtask
   task automatic trg(input logic v, input logic g);
      @(posedge clk_i);
      evt_i[0].trigger <= v;
      evt_i[0].gated_mode <= g;
   endtask
   task automatic irq_is(input logic [1:0] e);
      repeat (2) @(posedge clk_i);
      #1;
      chk(32'(irq_o), 32'(e));
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #20000;
      n_fail++;
      report_and_stop();
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(C1, 32'h0);
      rd(32'h4000F000, 32'h0);
      rd(F1, 32'h0);
      rd(A1, 32'h0000FFFF);
      rd(SET, 32'h0);
      wr(C1, 32'hFFFFFFFE);
      rd(C1, 32'h000000FE);
      rd(32'h4000E004, 32'h0);
      // output channel compare in each alignment, counter at rest counting up
      for (int m = 0; m < 4; m++)
      begin
         wr(C1, 32'(m) << 5);
         ev(4'h1);
         rd(F1, (m == 1) ? 32'h0 : 32'h2);
         wr(F1, 32'h3F);
      end
      wr(C1, 32'h0);
      ev(4'h1);
      ev(4'h1);
      rd(X1, 32'h1);
      wr(F1, 32'h0);
      rd(F1, 32'h2);
      wr(X1, 32'h1);
      rd(X1, 32'h0);
      wr(F1, 32'h2);
      // capture channel ignores alignment and clears on read
      evt_i[0].channel_is_input <= 4'h2;
      wr(C1, 32'h20);
      ev(4'h2);
      rd(F1, 32'h4);
      rd(32'h4000E038, 32'h0);
      rd(F1, 32'h0);
      wr(C1, 32'h0);
      wr(K1, 32'h2);
      rd(K1, 32'h2);
      wr(SET, 32'h1);
      rd(CLR, 32'h1);
      ev(4'h1);
      irq_is(2'b01);
      wr(K1, 32'h1);
      irq_is(2'b00);
      wr(K1, 32'h2);
      irq_is(2'b01);
      wr(CLR, 32'h1);
      irq_is(2'b00);
      wr(F1, 32'h3F);
      evt_i[0].trigger_mode <= 1'b1;
      trg(1'b1, 1'b0);
      rd(F1, 32'h1);
      rd(C1, 32'h1);
      wr(F1, 32'h1);
      trg(1'b0, 1'b0);
      rd(F1, 32'h0);
      trg(1'b1, 1'b1);
      wr(F1, 32'h1);
      trg(1'b0, 1'b1);
      rd(F1, 32'h1);
      evt_i[0].trigger_mode <= 1'b0;
      wr(F1, 32'h3F);
      wr(C1, 32'h1);
      evt_i[0].count_tick <= 1'b1;
      evt_i[1].count_tick <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1 c = count_o[0];
      @(posedge clk_i);
      #1 chk(32'(count_o[0]), 32'(c + 16'h1));
      chk(32'(count_o[1]), 32'h0);
      wr(C1, 32'h11);
      repeat (2) @(posedge clk_i);
      #1 c = count_o[0];
      @(posedge clk_i);
      #1 chk(32'(count_o[0]), 32'(c - 16'h1));
      evt_i[0].count_tick <= 1'b0;
      wr(C1, 32'h02);
      wr(F1, 32'h3F);
      wr(U1, 32'h1);
      rd(F1, 32'h0);
      chk(32'(count_o[0]), 32'h0);
      wr(C1, 32'h04);
      wr(U1, 32'h1);
      rd(F1, 32'h0);
      wr(C1, 32'h0);
      wr(U1, 32'h1);
      rd(F1, 32'h20);
      wr(F1, 32'h3F);
      wr(A1, 32'h3);
      wr(C1, 32'h09);
      evt_i[0].count_tick <= 1'b1;
      repeat (12) @(posedge clk_i);
      evt_i[0].count_tick <= 1'b0;
      rd(C1, 32'h08);
      rd(F1, 32'h20);
      chk(32'(irq_o), 32'h0);
      // buffered reload keeps the old end point until the update event
      wr(F1, 32'h3F);
      wr(C1, 32'h80);
      wr(A1, 32'h10);
      wr(C1, 32'h81);
      evt_i[0].count_tick <= 1'b1;
      repeat (6) @(posedge clk_i);
      evt_i[0].count_tick <= 1'b0;
      rd(F1, 32'h20);
      // second timer: trigger flag through its own mask and enable
      wr(32'h4000F054, 32'h1);
      wr(SET, 32'h2);
      @(posedge clk_i);
      evt_i[1].trigger <= 1'b1;
      irq_is(2'b10);
      report_and_stop();
   end
endmodule
